// [dps_pkg.sv]
package dps_pkg;
	// register word offsets (byte address = index * 4)
	localparam logic [3:0] ADDR_STALL = 4'h0;
	localparam logic [3:0] ADDR_RESTART = 4'h1;
	localparam logic [3:0] ADDR_EXTFAULT = 4'h2;
	localparam logic [3:0] ADDR_PHASEFAN = 4'h3;
	localparam logic [3:0] ADDR_THERMAL = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam logic [3:0] ADDR_CONTROL = 4'h6;
	localparam logic [3:0] SEL_RESET = 4'h0;
	// digit positions
	localparam int D1 = 0;
	localparam int D2 = 1;
	localparam int D3 = 2;
	localparam int D4 = 3;
	localparam logic [1:0] ACT_RAMP1 = 2'h0;
	localparam logic [1:0] ACT_COAST = 2'h1;
	localparam logic [1:0] ACT_RAMP2 = 2'h2;
	localparam logic [1:0] ACT_MINOR = 2'h3;
	localparam int CLK_MHZ = 250;
	localparam int RUN_STALL_MS = 100;
	localparam int RUN_STALL_CYC = RUN_STALL_MS * 1000 * CLK_MHZ;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [6:0] PCT_OPL_MIN = 7'h1e;
	localparam logic [7:0] FAN_ON_DEGC = 8'h32;
	localparam int THERM_STD_MIN = 8;
	localparam int THERM_SHORT_MIN = 5;
	localparam logic [31:0] OVERLOAD_STD = 32'h00f0_0000;
	localparam logic [31:0] OVERLOAD_SHORT = 32'h0096_0000;
	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_TIMING = 2'b01,
		RS_DECEL = 2'b10
	} dps_run_stall_type;
	typedef struct packed {
		logic stop_req;
		logic coast;
		logic use_decel_two;
		logic cut_output;
	} dps_stop_type;
	typedef struct packed {
		logic accel_hold;
		logic decel_hold;
		logic run_decel;
		logic decel_two;
	} dps_ramp_type;
endpackage

// [dps_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - accel stall bit: 0 enables, 1 disables; disabled accel follows programmed rate
// - accel stall holds ramp on current; above base frequency limit scaled by base over output frequency
// - decel stall bit 0 holds ramp on DC bus voltage; 1 uses plain rate
// - running stall decelerates after 100 ms over level; reaccelerates below it
// - running stall bit: 0 enables, 1 disables
// - accel and decel stall stay active during running stall
// - running stall ramp bit selects decel time one or two
// - restart bit decides fault contact during auto reset and restart
// - power loss: off faults at once; on faults only past ride-through time
// - external fault three shows code, asserts contact, stops, latches until reset
// - polarity bit: 0 normally open, 1 normally closed
// - acceptance bit: 0 always, 1 only while running not blocked
// - action field: ramp one, coast, ramp two, or continue as minor fault
// - input phase loss acts when enabled and level not 100 percent
// - output phase loss enabled, running, no DC braking, current above 30 percent
// - fan bit: 0 fan always on, 1 only above 50 degrees
// - thermal bit: 0 enables overload protection, 1 disables
// - curve bit selects reduced-torque or constant-torque characteristic
// - time constant bit selects 8 minute or 5 minute rating
// - integrate current heating; overload raises error and cuts output
module dps_top
	import dps_pkg::*;
#(
	parameter int RUN_STALL_CYCLES = RUN_STALL_CYC,
	parameter logic [31:0] RIDE_SCALE = 32'h0000_0001
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [15:0] output_current_in,
	input wire logic [15:0] accel_stall_level_in,
	input wire logic [15:0] running_stall_level_in,
	input wire logic [15:0] output_freq_in,
	input wire logic [15:0] base_frequency_in,
	input wire logic dc_bus_high_in,
	input wire logic freq_agree_in,
	input wire logic accelerating_in,
	input wire logic decelerating_in,
	input wire logic running_in,
	input wire logic output_blocked_in,
	input wire logic dc_braking_in,
	input wire logic [6:0] current_pct_in,
	input wire logic [6:0] input_loss_detect_level_in,
	input wire logic input_loss_raw_in,
	input wire logic output_loss_raw_in,
	input wire logic [7:0] heatsink_degc_in,
	input wire logic auto_restart_in,
	input wire logic power_loss_in,
	input wire logic [31:0] ride_through_time_in,
	input wire logic ext_fault_pin_in,
	input wire logic fault_reset_pin_in,
	output dps_ramp_type ramp_out,
	output dps_stop_type stop_out,
	output logic fault_contact_out,
	output logic fan_on_out,
	output logic undervoltage_fault_out,
	output logic external_fault_three_out,
	output logic ext_minor_out,
	output logic motor_overload_error_out,
	output logic input_phase_loss_out,
	output logic output_phase_loss_out
);
	////////////////////////////////////////////////////////////////////////////////
	logic [3:0] stall_sel_q, restart_sel_q, ext_sel_q, phase_sel_q, therm_sel_q;
	logic [31:0] rdata_d;
	logic [31:0] status_w;
	logic [1:0] ext_sync_q, rst_sync_q;
	logic ext_active, fault_reset_q, fault_reset_prev_q, fault_reset_pulse;
	logic ext_latch_q, ext_minor_q, uv_q, ipl_q, opl_q, ol_q;
	logic [31:0] loss_cnt_q, heat_q;
	logic [31:0] stall_cnt_q;
	dps_run_stall_type rs_q;
	logic [31:0] accel_lim, scaled;
	logic [47:0] prod;
	logic [31:0] heat_add, overload_lim;
	logic run_enabled, major_fault;

	assign avs_waitrequest_out = 1'b0;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			stall_sel_q <= SEL_RESET;
			restart_sel_q <= SEL_RESET;
			ext_sel_q <= SEL_RESET;
			phase_sel_q <= SEL_RESET;
			therm_sel_q <= SEL_RESET;
		end else if (avs_write_in && avs_byteenable_in[0]) begin
			unique case (avs_address_in)
				ADDR_STALL: stall_sel_q <= avs_writedata_in[3:0];
				ADDR_RESTART: restart_sel_q <= avs_writedata_in[3:0];
				ADDR_EXTFAULT: ext_sel_q <= avs_writedata_in[3:0];
				ADDR_PHASEFAN: phase_sel_q <= avs_writedata_in[3:0];
				ADDR_THERMAL: therm_sel_q <= avs_writedata_in[3:0];
				default: ;
			endcase
		end
	end

	assign status_w = {22'h0, ol_q, opl_q, ipl_q, uv_q, ext_minor_q, ext_latch_q,
		fault_contact_out, fan_on_out, rs_q};

	always_comb begin
		rdata_d = 32'h0;
		unique case (avs_address_in)
			ADDR_STALL: rdata_d = {28'h0, stall_sel_q};
			ADDR_RESTART: rdata_d = {28'h0, restart_sel_q};
			ADDR_EXTFAULT: rdata_d = {28'h0, ext_sel_q};
			ADDR_PHASEFAN: rdata_d = {28'h0, phase_sel_q};
			ADDR_THERMAL: rdata_d = {28'h0, therm_sel_q};
			ADDR_STATUS: rdata_d = status_w;
			default: rdata_d = 32'h0;
		endcase
	end

	// read data registered would cost a wait state; zero-wait keeps the bus simple
	assign avs_readdata_out = avs_read_in ? rdata_d : 32'h0;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ext_sync_q <= 2'h0;
			rst_sync_q <= 2'h0;
			fault_reset_prev_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], ext_fault_pin_in};
			rst_sync_q <= {rst_sync_q[0], fault_reset_pin_in};
			fault_reset_prev_q <= rst_sync_q[1];
		end
	end
	assign fault_reset_q = rst_sync_q[1];
	assign fault_reset_pulse = fault_reset_q & ~fault_reset_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// stall prevention
	assign prod = accel_stall_level_in * base_frequency_in;
	always_comb begin
		scaled = 32'h0;
		if (output_freq_in != 16'h0)
			scaled = 32'(prod / output_freq_in);
		accel_lim = {16'h0, accel_stall_level_in};
		if (output_freq_in > base_frequency_in)
			accel_lim = scaled;
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rs_q <= RS_IDLE;
			stall_cnt_q <= 32'h0;
		end else begin
			unique case (rs_q)
				RS_IDLE: begin
					stall_cnt_q <= 32'h0;
					if (!stall_sel_q[D3] && freq_agree_in &&
						output_current_in > running_stall_level_in)
						rs_q <= RS_TIMING;
				end
				RS_TIMING: begin
					if (stall_sel_q[D3] || output_current_in <= running_stall_level_in)
						rs_q <= RS_IDLE;
					else if (stall_cnt_q >= 32'(RUN_STALL_CYCLES - 1))
						rs_q <= RS_DECEL;
					else
						stall_cnt_q <= stall_cnt_q + 32'h1;
				end
				RS_DECEL: begin
					if (stall_sel_q[D3] || output_current_in <= running_stall_level_in)
						rs_q <= RS_IDLE;
				end
				default: rs_q <= RS_IDLE;
			endcase
		end
	end

	// accel and decel holds stay independent of the running stall state
	always_comb begin
		ramp_out.accel_hold = !stall_sel_q[D1] && accelerating_in &&
			({16'h0, output_current_in} > accel_lim);
		ramp_out.decel_hold = !stall_sel_q[D2] && decelerating_in && dc_bus_high_in;
		ramp_out.run_decel = rs_q == RS_DECEL;
		ramp_out.decel_two = stall_sel_q[D4];
	end

	////////////////////////////////////////////////////////////////////////////////
	// external fault three
	assign ext_active = ext_sync_q[1] ^ ext_sel_q[D1];
	assign run_enabled = !ext_sel_q[D2] || (running_in && !output_blocked_in);

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ext_latch_q <= 1'b0;
			ext_minor_q <= 1'b0;
		end else if (ext_active && run_enabled) begin
			ext_latch_q <= ext_sel_q[D4:D3] != ACT_MINOR;
			ext_minor_q <= ext_sel_q[D4:D3] == ACT_MINOR;
		end else if (fault_reset_pulse) begin
			ext_latch_q <= 1'b0;
			ext_minor_q <= 1'b0;
		end
	end

	always_comb begin
		stop_out.stop_req = ext_latch_q || uv_q || ol_q;
		stop_out.coast = (ext_latch_q && ext_sel_q[D4:D3] == ACT_COAST) || uv_q || ol_q;
		stop_out.use_decel_two = ext_latch_q && ext_sel_q[D4:D3] == ACT_RAMP2;
		stop_out.cut_output = uv_q || ol_q || (ext_latch_q && ext_sel_q[D4:D3] == ACT_COAST);
	end

	////////////////////////////////////////////////////////////////////////////////
	// momentary power loss
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			uv_q <= 1'b0;
			loss_cnt_q <= 32'h0;
		end else begin
			if (!power_loss_in)
				loss_cnt_q <= 32'h0;
			else
				loss_cnt_q <= loss_cnt_q + 32'h1;
			if (power_loss_in && (!restart_sel_q[D3] ||
				loss_cnt_q >= 32'(ride_through_time_in * RIDE_SCALE)))
				uv_q <= 1'b1;
			else if (fault_reset_pulse)
				uv_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// phase loss and fan
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ipl_q <= 1'b0;
			opl_q <= 1'b0;
			fan_on_out <= 1'b0;
		end else begin
			if (input_loss_raw_in && phase_sel_q[D1] && input_loss_detect_level_in != PCT_FULL)
				ipl_q <= 1'b1;
			else if (fault_reset_pulse)
				ipl_q <= 1'b0;
			if (output_loss_raw_in && phase_sel_q[D2] && running_in && !dc_braking_in &&
				current_pct_in > PCT_OPL_MIN)
				opl_q <= 1'b1;
			else if (fault_reset_pulse)
				opl_q <= 1'b0;
			fan_on_out <= !phase_sel_q[D3] || heatsink_degc_in > FAN_ON_DEGC;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// electronic thermal: output current minus a cooling term, rating by time constant
	always_comb begin
		heat_add = {16'h0, output_current_in};
		if (!therm_sel_q[D2] && output_freq_in < base_frequency_in)
			heat_add = {15'h0, output_current_in, 1'b0}; // self-cooled motor heats faster slow
		overload_lim = therm_sel_q[D3] ? OVERLOAD_SHORT : OVERLOAD_STD;
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			heat_q <= 32'h0;
			ol_q <= 1'b0;
		end else begin
			if (therm_sel_q[D1])
				heat_q <= 32'h0;
			else if (heat_q + heat_add > 32'(running_stall_level_in))
				heat_q <= heat_q + heat_add - 32'(running_stall_level_in);
			else
				heat_q <= 32'h0;
			if (!therm_sel_q[D1] && heat_q >= overload_lim)
				ol_q <= 1'b1;
			else if (fault_reset_pulse)
				ol_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign major_fault = ext_latch_q || uv_q || ol_q || ipl_q || opl_q;
	always_comb begin
		fault_contact_out = major_fault && (!auto_restart_in || restart_sel_q[D2]);
		undervoltage_fault_out = uv_q;
		external_fault_three_out = ext_latch_q;
		ext_minor_out = ext_minor_q;
		motor_overload_error_out = ol_q;
		input_phase_loss_out = ipl_q;
		output_phase_loss_out = opl_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	fan_sel_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		!phase_sel_q[D3] |=> fan_on_out) else $error("fan off while forced on");
	ext_latch_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		ext_latch_q && !fault_reset_pulse |=> ext_latch_q) else $error("fault lost");
	ext_minor_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		ext_minor_q |-> !ext_latch_q) else $error("minor also major");
	coast_sel_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		ext_latch_q && ext_sel_q[D4:D3] == ACT_COAST |-> stop_out.coast)
		else $error("no coast");
	uv_off_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		power_loss_in && !restart_sel_q[D3] |=> uv_q) else $error("no uv");
	ipl_gate_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		$rose(ipl_q) |-> $past(phase_sel_q[D1]) && $past(input_loss_detect_level_in) != PCT_FULL)
		else $error("ipl not gated");
	opl_gate_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		$rose(opl_q) |-> $past(current_pct_in) > PCT_OPL_MIN) else $error("opl low current");
	run_stall_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		stall_sel_q[D3] |=> rs_q == RS_IDLE) else $error("stall while off");
	therm_off_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		therm_sel_q[D1] |=> heat_q == 32'h0) else $error("heat while off");
	contact_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		ext_latch_q && !auto_restart_in |-> fault_contact_out) else $error("no contact");
	ext_c: cover property (@(posedge ref_clk_in) disable iff (reset_in) $rose(ext_latch_q));
	stall_c: cover property (@(posedge ref_clk_in) disable iff (reset_in) rs_q == RS_DECEL);
	uv_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
		restart_sel_q[D3] && $rose(uv_q));
	ol_c: cover property (@(posedge ref_clk_in) disable iff (reset_in) $rose(ol_q));
endmodule
`default_nettype wire

// [dps_motor_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dps_motor_model
	import dps_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic run_cmd_in,
	input wire logic [15:0] load_in,
	input wire dps_stop_type stop_in,
	output logic running_out,
	output logic [15:0] current_out,
	output logic [15:0] freq_out
);
	// no ramp modelled: a stop or cut drops the shaft at once, so tests never wait on speed
	always_ff @(posedge ref_clk_in) begin
		running_out <= run_cmd_in & ~stop_in.stop_req & ~stop_in.cut_output;
	end
	// a stopped motor draws nothing and sits at zero speed
	assign current_out = running_out ? load_in : 16'h0000;
	assign freq_out = running_out ? 16'h0100 : 16'h0000;
endmodule
`default_nettype wire

// [tb_drive_protection_select.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_drive_protection_select;
	import dps_pkg::*;
	localparam int RSC = 10;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [3:0] be = 4'hf;
	logic rd = 1'b0, wr = 1'b0, run_cmd = 1'b0, wreq, running;
	logic [31:0] wdata = 32'h0, rdata, v, rtt = 32'h0;
	logic [15:0] load = 16'h0, acc_lvl = 16'h0400, run_lvl = 16'h0400, base_f = 16'h0200;
	logic [15:0] cur, freq;
	logic dc_hi = 0, accel = 0, decel = 0, blocked = 0, braking = 0, ilr = 0, olr = 0;
	logic restart = 0, ploss = 0, ext_pin = 0, frst = 0;
	logic [6:0] pct = 7'h0, il_lvl = 7'h64;
	logic [7:0] degc = 8'h14;
	dps_ramp_type ramp;
	dps_stop_type stop;
	logic contact, fan, uv, ef3, minor, ol, input_phase_loss, output_phase_loss;
	int n_mismatch = 0, comparisons = 0, cycles = 0, i;

	always #2 ref_clk_in = ~ref_clk_in;

	dps_motor_model i_motor (.ref_clk_in(ref_clk_in), .run_cmd_in(run_cmd), .load_in(load),
		.stop_in(stop), .running_out(running), .current_out(cur), .freq_out(freq));

	dps_top #(.RUN_STALL_CYCLES(RSC)) i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.output_current_in(cur), .accel_stall_level_in(acc_lvl),
		.running_stall_level_in(run_lvl), .output_freq_in(freq), .base_frequency_in(base_f),
		.dc_bus_high_in(dc_hi), .freq_agree_in(running), .accelerating_in(accel),
		.decelerating_in(decel), .running_in(running), .output_blocked_in(blocked),
		.dc_braking_in(braking), .current_pct_in(pct), .input_loss_detect_level_in(il_lvl),
		.input_loss_raw_in(ilr), .output_loss_raw_in(olr), .heatsink_degc_in(degc),
		.auto_restart_in(restart), .power_loss_in(ploss), .ride_through_time_in(rtt),
		.ext_fault_pin_in(ext_pin), .fault_reset_pin_in(frst), .ramp_out(ramp),
		.stop_out(stop), .fault_contact_out(contact), .fan_on_out(fan),
		.undervoltage_fault_out(uv), .external_fault_three_out(ef3), .ext_minor_out(minor),
		.motor_overload_error_out(ol), .input_phase_loss_out(input_phase_loss), .output_phase_loss_out(output_phase_loss));

	////////////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask

	// one idle edge after each release so the next request never lands in the same step
	task bw(input logic [3:0] a, input logic [3:0] d, input logic [3:0] b = 4'hf);
		addr <= a;
		wdata <= {28'h0000000, d};
		be <= b;
		wr <= 1'b1;
		@(posedge ref_clk_in);
		while (wreq !== 1'b0) @(posedge ref_clk_in);
		wr <= 1'b0;
		@(posedge ref_clk_in);
	endtask

	task br(input logic [3:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_in);
		while (wreq !== 1'b0) @(posedge ref_clk_in);
		d = rdata;
		rd <= 1'b0;
		@(posedge ref_clk_in);
	endtask

	task clr;
		frst <= 1'b1;
		cyc(4);
		frst <= 1'b0;
		cyc(4);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		cyc(10);
		reset_in <= 1'b0;
		cyc(2);
		chk("fan_rst", fan, 1);
		chk("no_wait", wreq, 0);
		for (i = 0; i < 5; i++) begin
			br(i[3:0], v);
			chk("reg_rst", v, 0);
			bw(i[3:0], 4'ha);
			br(i[3:0], v);
			chk("reg_rw", v, 32'ha);
			bw(i[3:0], 4'h0);
		end
		br(ADDR_CONTROL, v);
		chk("unmapped", v, 0);
		bw(ADDR_THERMAL, 4'hf, 4'h0);
		br(ADDR_THERMAL, v);
		chk("be_off", v, 0);
		// running stall with the second ramp, decel stall kept alive meanwhile
		run_cmd <= 1'b1;
		bw(ADDR_STALL, 4'h8);
		load <= 16'h0800;
		decel <= 1'b1;
		dc_hi <= 1'b1;
		cyc(RSC - 2);
		chk("run_early", ramp.run_decel, 0);
		cyc(6);
		chk("run_decel", ramp.run_decel, 1);
		chk("decel_two", ramp.decel_two, 1);
		chk("dec_hold", ramp.decel_hold, 1);
		bw(ADDR_STALL, 4'ha);
		cyc(2);
		chk("dec_off", ramp.decel_hold, 0);
		load <= 16'h0200;
		cyc(3);
		chk("reaccel", ramp.run_decel, 0);
		bw(ADDR_STALL, 4'h4);
		load <= 16'h0800;
		cyc(RSC + 6);
		chk("run_off", ramp.run_decel, 0);
		// acceleration limit scaled down above base frequency
		decel <= 1'b0;
		bw(ADDR_STALL, 4'h0);
		accel <= 1'b1;
		load <= 16'h0300;
		cyc(3);
		chk("acc_base", ramp.accel_hold, 0);
		base_f <= 16'h0080;
		cyc(3);
		chk("acc_scaled", ramp.accel_hold, 1);
		bw(ADDR_STALL, 4'h1);
		cyc(2);
		chk("acc_off", ramp.accel_hold, 0);
		accel <= 1'b0;
		dc_hi <= 1'b0;
		base_f <= 16'h0200;
		load <= 16'h0100;
		for (i = 0; i < 4; i++) begin
			bw(ADDR_EXTFAULT, {i[1:0], 2'b00});
			ext_pin <= 1'b1;
			cyc(5);
			chk("ef3", ef3, i < 3);
			chk("minor", minor, i == 3);
			chk("stop", stop.stop_req, i < 3);
			chk("coast", stop.coast, i == 1);
			chk("ramp2", stop.use_decel_two, i == 2);
			if (i < 3)
				chk("contact", contact, 1);
			if (i == 0) begin
				restart <= 1'b1;
				cyc(2);
				chk("rst_quiet", contact, 0);
				bw(ADDR_RESTART, 4'h2);
				chk("rst_shown", contact, 1);
				bw(ADDR_RESTART, 4'h0);
				restart <= 1'b0;
			end
			ext_pin <= 1'b0;
			cyc(4);
			chk("ef3_held", ef3 | minor, 1);
			clr();
			chk("ef3_clr", ef3 | minor, 0);
		end
		bw(ADDR_EXTFAULT, 4'h1);
		cyc(5);
		chk("nc_open", ef3, 1);
		ext_pin <= 1'b1;
		clr();
		chk("nc_closed", ef3, 0);
		run_cmd <= 1'b0;
		blocked <= 1'b1;
		bw(ADDR_EXTFAULT, 4'h3);
		ext_pin <= 1'b0;
		cyc(6);
		chk("blocked", ef3, 0);
		blocked <= 1'b0;
		run_cmd <= 1'b1;
		cyc(6);
		chk("running", ef3, 1);
		ext_pin <= 1'b1;
		clr();
		ploss <= 1'b1;
		cyc(3);
		chk("uv_now", uv, 1);
		ploss <= 1'b0;
		clr();
		bw(ADDR_RESTART, 4'h4);
		rtt <= 32'h14;
		ploss <= 1'b1;
		cyc(8);
		ploss <= 1'b0;
		cyc(2);
		chk("uv_ride", uv, 0);
		ploss <= 1'b1;
		cyc(30);
		chk("uv_long", uv, 1);
		ploss <= 1'b0;
		clr();
		bw(ADDR_PHASEFAN, 4'h1);
		ilr <= 1'b1;
		cyc(3);
		chk("ipl_full", input_phase_loss, 0);
		il_lvl <= 7'h32;
		cyc(3);
		chk("ipl_on", input_phase_loss, 1);
		ilr <= 1'b0;
		clr();
		bw(ADDR_PHASEFAN, 4'h2);
		olr <= 1'b1;
		pct <= 7'h1e;
		cyc(3);
		chk("opl_low", output_phase_loss, 0);
		braking <= 1'b1;
		pct <= 7'h1f;
		cyc(3);
		chk("opl_brake", output_phase_loss, 0);
		braking <= 1'b0;
		cyc(3);
		chk("opl_on", output_phase_loss, 1);
		olr <= 1'b0;
		clr();
		bw(ADDR_PHASEFAN, 4'h4);
		degc <= 8'h32;
		cyc(3);
		chk("fan_50", fan, 0);
		degc <= 8'h33;
		cyc(3);
		chk("fan_51", fan, 1);
		// several motors on one drive: internal protection switched off
		bw(ADDR_THERMAL, 4'h1);
		run_lvl <= 16'h0000;
		load <= 16'hffff;
		cyc(400);
		chk("ol_off", ol, 0);
		bw(ADDR_THERMAL, 4'h0);
		cyc(400);
		chk("ol_on", ol, 1);
		// constant-torque curve with the short rating: no doubling, lower ceiling
		bw(ADDR_THERMAL, 4'h1);
		clr();
		bw(ADDR_THERMAL, 4'h6);
		cyc(120);
		chk("ol_short_early", ol, 0);
		cyc(40);
		chk("ol_short", ol, 1);
		wrap_up();
	end
endmodule
`default_nettype wire
